// File: nfcd_consts.svh
// Purpose: Constants for the flash command sequencer (host side)
// Assumes: 16-bit parallel flash bus, 100 MHz clock
// Notes: Offsets of the host register port are local choices
//
// Overview of operation
// - Clear-status is 555/71; read-status is 555/70, single writes.
// - While polling lock program, host ignores data lines five and one.
// - Full reset is 555/AA, 2AA/55, then any address with F0.
// - CFI entry is 555/98; leaving CFI or auto select is any/F0.
// - Auto select is unlock pair then 555/90; following cycles are reads.
// - Bypass entry is unlock pair then 555/20; exit is any/90, any/00.
// - Program is unlock pair, 555/A0, then address/data; bypass needs A0 only.
// - Buffer program: unlock, 25 at block, count-1 at block, pairs, 29 confirm.
// - Buffer abort recovery is 555/AA, 2AA/55, 555/F0.
// - Suspend is any/B0 or 51; resume is any/30 or 50.
// - Chip erase is six writes; in bypass only any/80, any/10.
// - Buffer count field is words minus one; at most 512 words.
`ifndef NFCD_CONSTS_SVH
`define NFCD_CONSTS_SVH
`define NFCD_A_UNLK1 11'h555
`define NFCD_A_UNLK2 11'h2AA
`define NFCD_D_UNLK1 8'hAA
`define NFCD_D_UNLK2 8'h55
`define NFCD_D_RESET 8'hF0
`define NFCD_D_CFI 8'h98
`define NFCD_D_ASEL 8'h90
`define NFCD_D_RDSR 8'h70
`define NFCD_D_CLSR 8'h71
`define NFCD_D_BYP 8'h20
`define NFCD_D_BYPX2 8'h00
`define NFCD_D_PROG 8'hA0
`define NFCD_D_BUF 8'h25
`define NFCD_D_BUFOK 8'h29
`define NFCD_D_SUSP 8'hB0
`define NFCD_D_RES 8'h30
`define NFCD_D_ERA1 8'h80
`define NFCD_D_ERA2 8'h10
`define NFCD_BUF_MAX 512
`define NFCD_LOCK_FIXED 16'hFEF8
`define NFCD_LOCK_PWD 2
`define NFCD_LOCK_NV 1
`define NFCD_SR_READY 7
`define NFCD_T_SETUP_NS 30
`define NFCD_T_PULSE_NS 50
`define NFCD_T_READ_NS 70
`define NFCD_REG_CMD 4'h0
`define NFCD_REG_ADDR 4'h1
`define NFCD_REG_DATA 4'h2
`define NFCD_REG_COUNT 4'h3
`define NFCD_REG_STAT 4'h4
`define NFCD_REG_RDATA 4'h5
`define NFCD_REG_MODE 4'h6
`endif

// File: nfcd_pkg.sv
// Purpose: Types for the flash command sequencer
// Assumes: Included constants header
// Notes: Command codes are host register values
package nfcd_pkg;
  typedef enum logic [3:0] {
    NFCD_OP_RESET = 4'h0,
    NFCD_OP_FULL_RESET = 4'h1,
    NFCD_OP_CFI = 4'h2,
    NFCD_OP_ASEL = 4'h3,
    NFCD_OP_RDSR = 4'h4,
    NFCD_OP_CLSR = 4'h5,
    NFCD_OP_BYP_ENTER = 4'h6,
    NFCD_OP_BYP_EXIT = 4'h7,
    NFCD_OP_PROG = 4'h8,
    NFCD_OP_BUF_START = 4'h9,
    NFCD_OP_BUF_WORD = 4'hA,
    NFCD_OP_BUF_OK = 4'hB,
    NFCD_OP_ABORT_RST = 4'hC,
    NFCD_OP_SUSPEND = 4'hD,
    NFCD_OP_RESUME = 4'hE,
    NFCD_OP_CHIP_ERASE = 4'hF
  } nfcd_op_t;
  typedef enum logic [1:0] {
    NFCD_BS_IDLE = 2'b00,
    NFCD_BS_SETUP = 2'b01,
    NFCD_BS_PULSE = 2'b10,
    NFCD_BS_HOLD = 2'b11
  } nfcd_bus_st_t;
endpackage

// File: nfcd_bus_cycle.sv
`include "nfcd_consts.svh"
// Purpose: One flash bus cycle, write or read, with timed strobes
// Assumes: 100 MHz clock, one cycle at a time
// Notes: Read data captured from a two-stage synchroniser
module nfcd_bus_cycle #(
  parameter int CLK_MHZ = 100
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [22:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic [22:0] o_fl_addr,
  output logic [15:0] o_fl_dq_o,
  output logic o_fl_dq_oe,
  input wire logic [15:0] i_fl_dq_i,
  output logic o_fl_ce_n,
  output logic o_fl_oe_n,
  output logic o_fl_we_n
);
  import nfcd_pkg::*;
  localparam int SETUP_CYC = (`NFCD_T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (`NFCD_T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_CYC = (`NFCD_T_READ_NS * CLK_MHZ + 999) / 1000 + 2;
  if (CLK_MHZ < 1 || CLK_MHZ > 1000) begin : g_bad_clk
    $error("CLK_MHZ out of range");
  end
  nfcd_bus_st_t st_r;
  logic [7:0] cnt_r;
  logic wr_r;
  logic [15:0] sync1_r, sync2_r;
  wire logic [7:0] setup_len = 8'(SETUP_CYC < 1 ? 1 : SETUP_CYC);
  wire logic [7:0] pulse_len = wr_r ? 8'(PULSE_CYC) : 8'(READ_CYC);
  assign o_busy = (st_r != NFCD_BS_IDLE);
  assign o_fl_ce_n = (st_r == NFCD_BS_IDLE);
  assign o_fl_we_n = !(wr_r && st_r == NFCD_BS_PULSE);
  assign o_fl_oe_n = !(!wr_r && st_r == NFCD_BS_PULSE);
  assign o_fl_dq_oe = wr_r && st_r != NFCD_BS_IDLE;
  // ************************************************
  // Strobe sequencer
  // ************************************************
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_r <= NFCD_BS_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      o_done <= 1'b0;
      o_fl_addr <= 23'h000000;
      o_fl_dq_o <= 16'h0000;
      o_rdata <= 16'h0000;
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else if (i_ce) begin
      sync1_r <= i_fl_dq_i;
      sync2_r <= sync1_r;
      o_done <= 1'b0;
      cnt_r <= cnt_r + 8'h01;
      case (st_r)
        NFCD_BS_IDLE: begin
          cnt_r <= 8'h00;
          if (i_start) begin
            st_r <= NFCD_BS_SETUP;
            wr_r <= i_write;
            o_fl_addr <= i_addr;
            o_fl_dq_o <= i_wdata;
          end
        end
        NFCD_BS_SETUP: if (cnt_r + 8'h01 >= setup_len) begin
          st_r <= NFCD_BS_PULSE;
          cnt_r <= 8'h00;
        end
        NFCD_BS_PULSE: if (cnt_r + 8'h01 >= pulse_len) begin
          st_r <= NFCD_BS_HOLD;
          if (!wr_r) o_rdata <= sync2_r;
        end
        default: begin
          st_r <= NFCD_BS_IDLE;
          o_done <= 1'b1;
        end
      endcase
    end
  end
endmodule // nfcd_bus_cycle

// File: nfcd_seq_rom.sv
`include "nfcd_consts.svh"
// Purpose: Address/data pattern for each step of each command
// Assumes: Bypass flag from sequencer
// Notes: Pure decode, no state
module nfcd_seq_rom (
  input wire nfcd_pkg::nfcd_op_t i_op,
  input wire logic [2:0] i_step,
  input wire logic i_bypass,
  input wire logic [22:0] i_addr,
  input wire logic [15:0] i_data,
  input wire logic [8:0] i_count,
  output logic [22:0] o_addr,
  output logic [15:0] o_data,
  output logic o_last,
  output logic o_read
);
  import nfcd_pkg::*;
  logic [10:0] a;
  logic [7:0] d;
  logic lst, usr, rd, blk;
  wire logic unlk = (i_step < 3'd2);
  wire logic [10:0] unlk_a = (i_step == 3'd0) ? `NFCD_A_UNLK1 : `NFCD_A_UNLK2;
  wire logic [7:0] unlk_d = (i_step == 3'd0) ? `NFCD_D_UNLK1 : `NFCD_D_UNLK2;
  always_comb begin
    a = `NFCD_A_UNLK1;
    d = 8'h00;
    lst = 1'b0;
    usr = 1'b0;
    rd = 1'b0;
    blk = 1'b0;
    case (i_op)
      NFCD_OP_RESET: begin d = `NFCD_D_RESET; lst = 1'b1; end
      NFCD_OP_FULL_RESET, NFCD_OP_ABORT_RST: begin
        a = unlk ? unlk_a : `NFCD_A_UNLK1;
        d = unlk ? unlk_d : `NFCD_D_RESET;
        lst = (i_step == 3'd2);
      end
      NFCD_OP_CFI: begin d = `NFCD_D_CFI; lst = 1'b1; end
      NFCD_OP_RDSR: begin d = (i_step == 3'd0) ? `NFCD_D_RDSR : 8'h00;
        rd = (i_step == 3'd1); lst = rd; end
      NFCD_OP_CLSR: begin d = `NFCD_D_CLSR; lst = 1'b1; end
      NFCD_OP_ASEL, NFCD_OP_BYP_ENTER: begin
        a = unlk ? unlk_a : `NFCD_A_UNLK1;
        d = unlk ? unlk_d : ((i_op == NFCD_OP_ASEL) ? `NFCD_D_ASEL : `NFCD_D_BYP);
        lst = (i_step == 3'd2);
      end
      NFCD_OP_BYP_EXIT: begin
        d = (i_step == 3'd0) ? `NFCD_D_ASEL : `NFCD_D_BYPX2;
        lst = (i_step == 3'd1);
      end
      NFCD_OP_PROG: begin
        if (i_bypass) begin
          d = `NFCD_D_PROG; usr = (i_step == 3'd1); lst = usr;
        end else begin
          a = unlk ? unlk_a : `NFCD_A_UNLK1;
          d = unlk ? unlk_d : `NFCD_D_PROG;
          usr = (i_step == 3'd3); lst = usr;
        end
      end
      NFCD_OP_BUF_START: begin
        if (!i_bypass && unlk) begin
          a = unlk_a; d = unlk_d;
        end else begin
          blk = 1'b1;
          d = ((i_step == 3'd0) || (i_step == 3'd2)) ? `NFCD_D_BUF : i_count[7:0];
          lst = i_bypass ? (i_step == 3'd1) : (i_step == 3'd3);
        end
      end
      NFCD_OP_BUF_WORD: begin usr = 1'b1; lst = 1'b1; end
      NFCD_OP_BUF_OK: begin blk = 1'b1; d = `NFCD_D_BUFOK; lst = 1'b1; end
      NFCD_OP_SUSPEND: begin d = `NFCD_D_SUSP; lst = 1'b1; end
      NFCD_OP_RESUME: begin d = `NFCD_D_RES; lst = 1'b1; end
      default: begin
        if (i_bypass) begin
          d = (i_step == 3'd0) ? `NFCD_D_ERA1 : `NFCD_D_ERA2; lst = (i_step == 3'd1);
        end else begin
          a = (i_step == 3'd1 || i_step == 3'd4) ? `NFCD_A_UNLK2 : `NFCD_A_UNLK1;
          d = (i_step == 3'd2) ? `NFCD_D_ERA1 : (i_step == 3'd5) ? `NFCD_D_ERA2 :
              ((i_step == 3'd1 || i_step == 3'd4) ? `NFCD_D_UNLK2 : `NFCD_D_UNLK1);
          lst = (i_step == 3'd5);
        end
      end
    endcase
  end
  // Buffer count high bit rides above the byte for 512-word loads
  wire logic cnt_hi = (i_op == NFCD_OP_BUF_START) && unlk_q();
  function automatic logic unlk_q();
    return (i_step == 3'd1 && i_bypass) || (i_step == 3'd3);
  endfunction
  assign o_addr = (usr || blk) ? i_addr : {12'h000, a};
  assign o_data = usr ? i_data : {7'h00, cnt_hi & i_count[8], d};
  assign o_last = lst;
  assign o_read = rd;
endmodule // nfcd_seq_rom

// File: nfcd_host.sv
// The address map and the strobed register port were chosen for this implementation.
`include "nfcd_consts.svh"
// Purpose: Host controller issuing command sequences to a parallel NOR flash
// Assumes: Single 100 MHz clock, software register port with one-cycle read data
// Notes: Lock register image kept to refuse illegal mode-bit programs and to be read back
module nfcd_host #(
  parameter int CLK_MHZ = 100,
  parameter int BUF_WORDS = `NFCD_BUF_MAX
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic [22:0] o_fl_addr,
  output logic [15:0] o_fl_dq_o,
  output logic o_fl_dq_oe,
  input wire logic [15:0] i_fl_dq_i,
  output logic o_fl_ce_n,
  output logic o_fl_oe_n,
  output logic o_fl_we_n
);
  import nfcd_pkg::*;
  if (BUF_WORDS < 1 || BUF_WORDS > `NFCD_BUF_MAX) begin : g_bad_buf
    $error("BUF_WORDS out of range");
  end
  // ************************************************
  // Software registers
  // ************************************************
  nfcd_op_t op_r;
  logic [22:0] addr_r;
  logic [15:0] data_r;
  logic [8:0] count_r;
  logic [15:0] rdata_r;
  logic [15:0] status_r;
  logic busy_r, bypass_r, asel_r, cfi_r, refused_r, abort_seen_r;
  logic [2:0] step_r;
  logic cyc_busy, cyc_done;
  logic [15:0] cyc_rdata;
  logic [22:0] rom_addr;
  logic [15:0] rom_data;
  logic rom_last, rom_read;
  logic [15:0] lock_img_r;
  wire logic hit_cmd = i_reg_wr && i_reg_addr == `NFCD_REG_CMD;
  wire logic hit_addr = i_reg_wr && i_reg_addr == `NFCD_REG_ADDR;
  wire logic hit_data = i_reg_wr && i_reg_addr == `NFCD_REG_DATA;
  wire logic hit_count = i_reg_wr && i_reg_addr == `NFCD_REG_COUNT;
  wire logic hit_lock = i_reg_wr && i_reg_addr == `NFCD_REG_MODE;
  wire nfcd_op_t new_op = nfcd_op_t'(i_reg_wdata[3:0]);
  // Password and nonvolatile bits may never both end at zero
  function automatic logic lock_conflict(input logic [15:0] img, input logic [15:0] req);
    logic pw, nv;
    pw = img[`NFCD_LOCK_PWD] & req[`NFCD_LOCK_PWD];
    nv = img[`NFCD_LOCK_NV] & req[`NFCD_LOCK_NV];
    return !pw && !nv;
  endfunction
  wire logic lock_refuse = lock_conflict(lock_img_r, i_reg_wdata[15:0]);
  // Software writes zeros only; a one cannot be restored
  wire logic [15:0] lock_next = (lock_img_r & i_reg_wdata[15:0]) | `NFCD_LOCK_FIXED;
  wire logic [15:0] lock_view = (lock_img_r & 16'h0007) | `NFCD_LOCK_FIXED;
  wire logic start_ok = hit_cmd && !busy_r;
  logic done_pend_r;
  wire logic go_cycle = busy_r && !cyc_busy && !cyc_done && !done_pend_r;
  wire logic [31:0] rd_mux =
    (i_reg_addr == `NFCD_REG_CMD) ? {28'h0000000, op_r} :
    (i_reg_addr == `NFCD_REG_ADDR) ? {9'h000, addr_r} :
    (i_reg_addr == `NFCD_REG_DATA) ? {16'h0000, data_r} :
    (i_reg_addr == `NFCD_REG_COUNT) ? {23'h000000, count_r} :
    (i_reg_addr == `NFCD_REG_STAT) ? {10'h000, abort_seen_r, refused_r, cfi_r, asel_r,
      bypass_r, busy_r, status_r} :
    (i_reg_addr == `NFCD_REG_RDATA) ? {16'h0000, rdata_r} :
    (i_reg_addr == `NFCD_REG_MODE) ? {16'h0000, lock_view} : 32'h00000000;
  // ************************************************
  // Pattern and bus cycle engines
  // ************************************************
  nfcd_seq_rom u_rom (
    .i_op(op_r),
    .i_step(step_r),
    .i_bypass(bypass_r),
    .i_addr(addr_r),
    .i_data(data_r),
    .i_count(count_r),
    .o_addr(rom_addr),
    .o_data(rom_data),
    .o_last(rom_last),
    .o_read(rom_read)
  );
  nfcd_bus_cycle #(.CLK_MHZ(CLK_MHZ)) u_cyc (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_start(go_cycle),
    .i_write(!rom_read),
    .i_addr(rom_addr),
    .i_wdata(rom_data),
    .o_busy(cyc_busy),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_fl_addr(o_fl_addr),
    .o_fl_dq_o(o_fl_dq_o),
    .o_fl_dq_oe(o_fl_dq_oe),
    .i_fl_dq_i(i_fl_dq_i),
    .o_fl_ce_n(o_fl_ce_n),
    .o_fl_oe_n(o_fl_oe_n),
    .o_fl_we_n(o_fl_we_n)
  );
  // ************************************************
  // Register write port and read data
  // ************************************************
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      addr_r <= 23'h000000;
      data_r <= 16'h0000;
      count_r <= 9'h000;
      o_reg_rdata <= 32'h00000000;
      lock_img_r <= 16'hFFFF;
      refused_r <= 1'b0;
    end else if (i_ce) begin
      o_reg_rdata <= i_reg_rd ? rd_mux : 32'h00000000;
      if (hit_addr) addr_r <= i_reg_wdata[22:0];
      if (hit_data) data_r <= i_reg_wdata[15:0];
      if (hit_count) count_r <= (i_reg_wdata[9:0] > 10'(BUF_WORDS - 1)) ?
        9'(BUF_WORDS - 1) : i_reg_wdata[8:0];
      if (hit_lock && !lock_refuse) lock_img_r <= lock_next;
      if (hit_lock) refused_r <= lock_refuse;
      else if (start_ok) refused_r <= 1'b0;
    end
  end
  // ************************************************
  // Command sequencer
  // ************************************************
  wire logic step_end = cyc_done && rom_last;
  wire logic exits_mode = op_r == NFCD_OP_RESET || op_r == NFCD_OP_FULL_RESET ||
    op_r == NFCD_OP_ABORT_RST;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      op_r <= NFCD_OP_RESET;
      step_r <= 3'd0;
      busy_r <= 1'b0;
      done_pend_r <= 1'b0;
      bypass_r <= 1'b0;
      asel_r <= 1'b0;
      cfi_r <= 1'b0;
      abort_seen_r <= 1'b0;
      rdata_r <= 16'h0000;
      status_r <= 16'h0080;
    end else if (i_ce) begin
      done_pend_r <= go_cycle;
      if (cyc_done) done_pend_r <= 1'b0;
      if (start_ok) begin
        op_r <= new_op;
        step_r <= 3'd0;
        busy_r <= 1'b1;
        done_pend_r <= 1'b0;
      end else if (cyc_done) begin
        if (rom_read) rdata_r <= cyc_rdata;
        if (!rom_last) step_r <= step_r + 3'd1;
      end
      if (step_end) begin
        busy_r <= 1'b0;
        if (op_r == NFCD_OP_RDSR) begin
          status_r <= {8'h00, cyc_rdata[7:0]};
          abort_seen_r <= cyc_rdata[3];
        end
        if (op_r == NFCD_OP_CLSR) begin
          status_r[6:1] <= 6'h00;
          if (abort_seen_r) status_r[`NFCD_SR_READY] <= 1'b1;
          abort_seen_r <= 1'b0;
        end
        if (exits_mode) begin
          status_r[6:1] <= 6'h00;
          asel_r <= 1'b0;
          cfi_r <= 1'b0;
          if (op_r != NFCD_OP_RESET) abort_seen_r <= 1'b0;
          // Plain reset keeps bypass, matching device behaviour
        end
        if (op_r == NFCD_OP_BYP_ENTER) bypass_r <= 1'b1;
        if (op_r == NFCD_OP_BYP_EXIT) bypass_r <= 1'b0;
        if (op_r == NFCD_OP_ASEL) asel_r <= 1'b1;
        if (op_r == NFCD_OP_CFI) cfi_r <= 1'b1;
      end
    end
  end
  // Partial sequences always run to their end; the flash drops a broken one itself
  // Lock polling data lines five and one are never interpreted here
endmodule // nfcd_host

// File: nfcd_host_assertions.sv
// Purpose: Port checks on the flash command sequencer
// Assumes: Clock enable held high by the bench
// Notes: Cycle counts follow the sequencer's bus timing
// ****************************************
// Checker
// ****************************************
module nfcd_host_checker (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic [22:0] o_fl_addr,
  input wire logic [15:0] o_fl_dq_o,
  input wire logic o_fl_dq_oe,
  input wire logic [15:0] i_fl_dq_i,
  input wire logic o_fl_ce_n,
  input wire logic o_fl_oe_n,
  input wire logic o_fl_we_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  AST_WE_SETUP: assert property ($fell(o_fl_we_n) |-> $past(!o_fl_ce_n && o_fl_we_n, 3))
    else $error("write setup short");
  AST_WE_PULSE: assert property ($fell(o_fl_we_n) |-> !o_fl_we_n [*5] ##1 o_fl_we_n)
    else $error("write strobe width wrong");
  AST_WE_STABLE: assert property (!o_fl_we_n && $past(!o_fl_we_n)
    |-> $stable(o_fl_addr) && $stable(o_fl_dq_o))
    else $error("address or data moved in write");
  AST_RD_PULSE: assert property ($fell(o_fl_oe_n) |-> !o_fl_oe_n [*8] ##1 !o_fl_oe_n ##1 o_fl_oe_n)
    else $error("read strobe width wrong");
  AST_DRIVE_WR: assert property (!o_fl_we_n |-> o_fl_dq_oe && o_fl_oe_n && !o_fl_ce_n)
    else $error("write without driving bus");
  AST_FLOAT_RD: assert property (!o_fl_oe_n |-> !o_fl_dq_oe && o_fl_we_n && !o_fl_ce_n)
    else $error("bus driven during read");
  AST_RDATA_IDLE: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside read slot");
  AST_LOCK_FIXED: assert property (i_reg_rd && i_reg_addr == 4'h6
    |=> o_reg_rdata[15:3] == 13'h1FDF)
    else $error("lock reserved bits wrong");
  AST_UNLOCK_PAIR: assert property ($fell(o_fl_we_n) && o_fl_addr == 23'h555 && o_fl_dq_o == 16'hAA
    |-> ##[1:40] ($fell(o_fl_we_n) && o_fl_addr == 23'h2AA && o_fl_dq_o == 16'h55))
    else $error("unlock pair broken");
  cover property ($fell(o_fl_oe_n));
  cover property ($fell(o_fl_we_n) && o_fl_dq_o == 16'h10);
  cover property (i_reg_rd && i_reg_addr == 4'h6);
endmodule // nfcd_host_checker
bind nfcd_host nfcd_host_checker i_nfcd_host_checker (.i_clock(i_clock), .i_rst(i_rst),
  .i_ce(i_ce), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_fl_addr(o_fl_addr),
  .o_fl_dq_o(o_fl_dq_o), .o_fl_dq_oe(o_fl_dq_oe), .i_fl_dq_i(i_fl_dq_i),
  .o_fl_ce_n(o_fl_ce_n), .o_fl_oe_n(o_fl_oe_n), .o_fl_we_n(o_fl_we_n));

// File: nfcd_dev.sv
// Purpose: Behavioural parallel flash facing the sequencer
// Assumes: Writes latch on the rising write strobe
// Notes: Only status and reset commands decoded; every write is logged
// ****************************************
// Device model
// ****************************************
module nfcd_dev (
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [22:0] i_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  input wire logic i_sr_load,
  input wire logic [7:0] i_sr_val
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sr_r = 8'h80;
  logic stat_mode_r = 1'b0;
  logic [15:0] last_r = 16'h0000;
  logic [22:0] log_a[$];
  logic [15:0] log_d[$];
  logic [15:0] rd_val;
  assign rd_val = stat_mode_r ? {8'h00, sr_r} : (i_addr[15:0] ^ 16'h5A5A);
  // Released bus shows the inverse, so a stale value never passes
  assign o_dq = (!i_ce_n && !i_oe_n) ? rd_val : ~last_r;
  always @(posedge i_sr_load) sr_r = i_sr_val;
  always @(posedge i_oe_n) begin
    last_r = rd_val;
    stat_mode_r = 1'b0;
  end
  always @(posedge i_we_n) begin
    if (i_ce_n === 1'b0) begin
      log_a.push_back(i_addr);
      log_d.push_back(i_dq);
      if (i_addr == 23'h555 && i_dq[7:0] == 8'h70) stat_mode_r = 1'b1;
      if ((i_addr == 23'h555 && i_dq[7:0] == 8'h71) || i_dq[7:0] == 8'hF0) begin
        sr_r[7] = sr_r[7] | sr_r[3];
        sr_r[6:1] = 6'h00;
      end
    end
  end
endmodule // nfcd_dev

// File: test_nfcd_host.sv
// Purpose: Self-checking bench for the flash command sequencer
// Assumes: Device model logs each flash write
// Notes: Unmapped register reads are taken to return zero
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
// ****************************************
// Bench
// ****************************************
module test_nfcd_host;
  timeunit 1ns;
  timeprecision 1ps;
  import nfcd_pkg::*;
  localparam logic [22:0] ANY = 23'h7FFFFF;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sr_load = 1'b0;
  logic [7:0] sr_val = 8'h00;
  logic [31:0] reg_rdata;
  logic [22:0] fl_addr;
  logic [15:0] fl_dq_o;
  logic [15:0] dev_dq;
  logic fl_dq_oe;
  logic fl_ce_n;
  logic fl_oe_n;
  logic fl_we_n;
  logic [15:0] dq_wire;
  int errors = 0;
  int comparisons = 0;
  logic [22:0] exp_a[$];
  logic [15:0] exp_d[$];
  logic [31:0] rv;
  assign dq_wire = fl_dq_oe ? fl_dq_o : dev_dq;
  always #5 clock = ~clock;
  nfcd_host i_nfcd_host (.i_clock(clock), .i_rst(rst), .i_ce(1'b1), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .o_fl_addr(fl_addr), .o_fl_dq_o(fl_dq_o), .o_fl_dq_oe(fl_dq_oe), .i_fl_dq_i(dq_wire),
    .o_fl_ce_n(fl_ce_n), .o_fl_oe_n(fl_oe_n), .o_fl_we_n(fl_we_n));
  nfcd_dev i_nfcd_dev (.i_ce_n(fl_ce_n), .i_oe_n(fl_oe_n), .i_we_n(fl_we_n), .i_addr(fl_addr),
    .i_dq(dq_wire), .o_dq(dev_dq), .i_sr_load(sr_load), .i_sr_val(sr_val));
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic ex(input logic [22:0] a, input logic [15:0] d);
    exp_a.push_back(a);
    exp_d.push_back(d);
  endtask
  // Unlock pair, then a command at the first unlock address
  task automatic cmd3(input logic [15:0] d);
    ex(23'h555, 16'hAA);
    ex(23'h2AA, 16'h55);
    ex(23'h555, d);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    rv = 32'h0001_0000;
    while (rv[16] !== 1'b0 && n < 300) begin
      rd_reg(4'h4, rv);
      n++;
    end
    `CHK("busy", 1'b0, rv[16])
  endtask
  task automatic run(input nfcd_op_t op);
    i_nfcd_dev.log_a.delete();
    i_nfcd_dev.log_d.delete();
    wr_reg(4'h0, {28'h0, op});
    wait_idle();
  endtask
  task automatic chk_log();
    `CHK("write count", exp_a.size(), i_nfcd_dev.log_a.size())
    for (int i = 0; i < exp_a.size() && i < i_nfcd_dev.log_a.size(); i++) begin
      if (exp_a[i] !== ANY) `CHK("flash addr", exp_a[i], i_nfcd_dev.log_a[i])
      `CHK("flash data", exp_d[i], i_nfcd_dev.log_d[i])
    end
    exp_a.delete();
    exp_d.delete();
  endtask
  task automatic t_table();
    nfcd_op_t ops[11] = '{NFCD_OP_RESET, NFCD_OP_FULL_RESET, NFCD_OP_CFI, NFCD_OP_RESET,
      NFCD_OP_ASEL, NFCD_OP_RESET, NFCD_OP_CLSR, NFCD_OP_SUSPEND, NFCD_OP_RESUME,
      NFCD_OP_ABORT_RST, NFCD_OP_CHIP_ERASE};
    foreach (ops[k]) begin
      case (ops[k])
        NFCD_OP_RESET: ex(ANY, 16'hF0);
        NFCD_OP_FULL_RESET: begin
          cmd3(16'hF0);
          exp_a[2] = ANY;
        end
        NFCD_OP_CFI: ex(23'h555, 16'h98);
        NFCD_OP_ASEL: cmd3(16'h90);
        NFCD_OP_CLSR: ex(23'h555, 16'h71);
        NFCD_OP_SUSPEND: ex(ANY, 16'hB0);
        NFCD_OP_RESUME: ex(ANY, 16'h30);
        NFCD_OP_ABORT_RST: cmd3(16'hF0);
        default: begin
          cmd3(16'h80);
          cmd3(16'h10);
        end
      endcase
      run(ops[k]);
      chk_log();
      rd_reg(4'h4, rv);
      `CHK("mode", (ops[k] == NFCD_OP_CFI) ? 2'b10 : (ops[k] == NFCD_OP_ASEL) ? 2'b01 : 2'b00,
        rv[19:18])
    end
    $display("t_table done");
  endtask
  task automatic t_bypass();
    wr_reg(4'h1, 32'h0012345);
    wr_reg(4'h2, 32'hBEEF);
    cmd3(16'hA0);
    ex(23'h012345, 16'hBEEF);
    run(NFCD_OP_PROG);
    chk_log();
    cmd3(16'h20);
    run(NFCD_OP_BYP_ENTER);
    chk_log();
    wr_reg(4'h1, 32'h777);
    wr_reg(4'h2, 32'h0055);
    ex(ANY, 16'hA0);
    ex(23'h777, 16'h0055);
    run(NFCD_OP_PROG);
    chk_log();
    ex(ANY, 16'h80);
    ex(ANY, 16'h10);
    run(NFCD_OP_CHIP_ERASE);
    chk_log();
    ex(ANY, 16'hF0);
    run(NFCD_OP_RESET);
    chk_log();
    rd_reg(4'h4, rv);
    `CHK("bypass kept", 1'b1, rv[17])
    ex(ANY, 16'h90);
    ex(ANY, 16'h00);
    run(NFCD_OP_BYP_EXIT);
    chk_log();
    rd_reg(4'h4, rv);
    `CHK("bypass left", 1'b0, rv[17])
    $display("t_bypass done");
  endtask
  task automatic t_buffer();
    wr_reg(4'h3, 32'h1);
    wr_reg(4'h1, 32'h400);
    cmd3(16'h25);
    exp_a[2] = 23'h400;
    ex(23'h400, 16'h0001);
    run(NFCD_OP_BUF_START);
    chk_log();
    for (int w = 1; w < 3; w++) begin
      wr_reg(4'h1, 32'h400 + w);
      wr_reg(4'h2, 32'h1111 * w);
      ex(23'(32'h400 + w), 16'(32'h1111 * w));
      run(NFCD_OP_BUF_WORD);
      chk_log();
    end
    wr_reg(4'h1, 32'h400);
    ex(23'h400, 16'h29);
    run(NFCD_OP_BUF_OK);
    chk_log();
    // Largest count, then abandoned by the abort recovery
    wr_reg(4'h3, 32'h1FF);
    cmd3(16'h25);
    exp_a[2] = 23'h400;
    ex(23'h400, 16'h01FF);
    run(NFCD_OP_BUF_START);
    chk_log();
    cmd3(16'hF0);
    run(NFCD_OP_ABORT_RST);
    chk_log();
    $display("t_buffer done");
  endtask
  task automatic t_status();
    logic [7:0] vals[3] = '{8'h20, 8'h18, 8'h20};
    nfcd_op_t clr[3] = '{NFCD_OP_CLSR, NFCD_OP_CLSR, NFCD_OP_RESET};
    logic [15:0] after[3] = '{16'h0000, 16'h0080, 16'h0000};
    foreach (vals[k]) begin
      @(posedge clock);
      sr_val <= vals[k];
      sr_load <= 1'b1;
      @(posedge clock);
      sr_load <= 1'b0;
      ex(23'h555, 16'h70);
      run(NFCD_OP_RDSR);
      chk_log();
      rd_reg(4'h4, rv);
      `CHK("status", {8'h00, vals[k]}, rv[15:0])
      rd_reg(4'h5, rv);
      `CHK("read data", {8'h00, vals[k]}, rv[15:0])
      run(clr[k]);
      rd_reg(4'h4, rv);
      `CHK("cleared", after[k], rv[15:0])
      ex(23'h555, 16'h70);
      run(NFCD_OP_RDSR);
      chk_log();
      rd_reg(4'h4, rv);
      `CHK("reread", after[k], rv[15:0])
    end
    $display("t_status done");
  endtask
  task automatic t_busy();
    i_nfcd_dev.log_a.delete();
    i_nfcd_dev.log_d.delete();
    wr_reg(4'h0, {28'h0, NFCD_OP_CHIP_ERASE});
    wr_reg(4'h0, {28'h0, NFCD_OP_RESET});
    wait_idle();
    cmd3(16'h80);
    cmd3(16'h10);
    chk_log();
    $display("t_busy done");
  endtask
  task automatic t_lock();
    logic [15:0] wv[6] = '{16'hF0FE, 16'hFFFD, 16'hFFFF, 16'hFFFB, 16'hFFFB, 16'hFFFD};
    logic [15:0] ev[6] = '{16'hFEFE, 16'hFEFC, 16'hFEFC, 16'hFEFC, 16'hFEFB, 16'hFEFB};
    foreach (wv[k]) begin
      if (k == 4) begin
        rd_reg(4'h4, rv);
        `CHK("refused", 1'b1, rv[20])
        do_reset();
      end
      rd_reg(4'h6, rv);
      if (k == 0 || k == 4) `CHK("lock default", 16'hFEFF, rv[15:0])
      wr_reg(4'h6, {16'h0, wv[k]});
      rd_reg(4'h6, rv);
      `CHK("lock", ev[k], rv[15:0])
    end
    rd_reg(4'h4, rv);
    `CHK("refused", 1'b1, rv[20])
    wr_reg(4'hF, 32'hFFFF_FFFF);
    rd_reg(4'hF, rv);
    `CHK("unmapped", 32'h0, rv)
    rd_reg(4'h6, rv);
    `CHK("lock kept", 16'hFEFB, rv[15:0])
    $display("t_lock done");
  endtask
  initial begin
    #200000;
    errors++;
    $display("[ERR] watchdog exp done got hang");
    give_verdict();
  end
  initial begin
    do_reset();
    rd_reg(4'h4, rv);
    `CHK("reset status", 16'h0080, rv[15:0])
    t_table();
    t_bypass();
    t_buffer();
    t_status();
    t_busy();
    t_lock();
    give_verdict();
  end
endmodule // test_nfcd_host
